// ---- rtl/cfg_bank_map.svh ----
// Offsets, field codes, reset values and timing counts of the configuration register bank
`ifndef CFG_BANK_MAP_SVH
`define CFG_BANK_MAP_SVH

`define CFG_RESET_BYTE 8'h00
`define CFG_RESET_PAGE 4'h0
`define CFG_RESET_HOLD_CYCLES 16

`define CFG_OFS_PORT_A_IN 8'h00
`define CFG_OFS_PAGE 8'he0
`define CFG_OFS_IRQ_CLEAR 8'hd4
`define CFG_OFS_IRQ_ENABLE 8'hd3
`define CFG_OFS_IRQ_SENSE 8'hd2
`define CFG_OFS_IRQ_PENDING 8'hd1
`define CFG_OFS_IRQ_TOP 8'hd0
`define CFG_OFS_MEM_MODE 8'hc0
`define CFG_OFS_PWR_B 8'hb1
`define CFG_OFS_PWR_A 8'hb0
`define CFG_OFS_TMR_FLAGS 8'ha9
`define CFG_OFS_TMR_GLOBAL 8'ha8
`define CFG_OFS_TMR_DELAY 8'ha6
`define CFG_OFS_TMR_LDST 8'ha5
`define CFG_OFS_TMR_FREEZE 8'ha4
`define CFG_TMR_CFG_TAG 6'h28
`define CFG_TMR_COUNT_TAG 5'h13
`define CFG_TMR_SNAP_TAG 5'h12

`define CFG_FLD_PIN_IN 3'h0
`define CFG_FLD_MODE 3'h1
`define CFG_FLD_OUT 3'h2
`define CFG_FLD_DIR 3'h3
`define CFG_FLD_DRV_SF 3'h4
`define CFG_FLD_LOGIC 3'h5
`define CFG_FLD_MACRO 3'h6

`define CFG_ODRAIN_PORTS 5'h0c
`define CFG_LOGIC_PORTS 5'h13
`define CFG_PERIPH_PORT 0

`define CFG_MEM_SRAM_PROG_BIT 0
`define CFG_MEM_PERIPH_A_BIT 1
`define CFG_TMR_RUN_BIT 0

`endif

// ---- rtl/cfg_bank_pkg.sv ----
// Types shared by the configuration register bank
package cfg_bank_pkg;
    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;

    typedef struct packed {
        logic hit;
        logic [2:0] port;
        logic [2:0] field;
    } io_sel_t;

    typedef enum {ST_HOLD, ST_EXTEND, ST_RUN} rst_state_t;
endpackage

// ---- rtl/config_register_bank.sv ----
// Configuration and status register bank with port pin control, interrupts and timer images
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_map.svh"

// Summary of operation
// - Reading a port's pin-input register returns the live pin levels.
// - Mode bit 0 drives an address bit; 1 gives microcontroller general I/O.
// - Output-data register supplies the level of pins in general I/O mode.
// - Direction bit 0 makes the pin an input, 1 an output.
// - Drive-type bit 0 is push-pull, 1 is open-drain.
// - Special-function bit 1 routes a timer or interrupt output to the pin.
// - Logic-pin status is read-only; 1 marks a programmable-logic pin.
// - Macrocell-output register shows current general logic macrocell outputs.
// - A four-bit page register extends memory addressing.
// - Any read of the read-clear register clears all pending edge interrupts.
// - Sense register picks level or edge sensitivity per interrupt input.
// - Mask register gates individual interrupt inputs.
// - A 1 in the request latch marks a pending interrupt.
// - Priority status shows the highest-priority pending interrupt.
// - Memory-mode register maps SRAM to program fetch and enables peripheral mode.
// - Software freezes timers before image access; flags acknowledge the freeze.
// - Reset clears units and registers, and holds on for an interval after release.
// - Logic outputs keep running during reset; memories may answer unreliably.
// - After reset configuration registers are zero, counters undefined, interrupts off.
// - Macrocell flip-flops clear by a reset product term or macrocell reset input.
// - Timer control and interrupt controller state always clear on reset; timer counters and images do not.
// - Registers sit at fixed offsets inside a 256-byte selected window.
module config_register_bank #(
    parameter int RESET_HOLD = `CFG_RESET_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Register access from the microcontroller
    input wire cfg_bank_pkg::reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Port pins and their sources
    input wire logic [4:0][7:0] PIN_IN,
    input wire logic [4:0][7:0] ADDR_SRC,
    input wire logic [4:0][7:0] SPECIAL_SRC,
    output cfg_bank_pkg::pin_drive_t [4:0] PIN_DRIVE,
    // Programmable logic
    input wire logic [4:0][7:0] LOGIC_PIN_CFG,
    input wire logic [4:0][7:0] LOGIC_OUT,
    input wire logic [4:0][7:0] LOGIC_OE,
    input wire logic [4:0][7:0] MACRO_D,
    input wire logic [4:0][7:0] MACRO_CLR_TERM,
    input wire logic MACROCELL_RESET_INPUT,
    // Peripheral data path on the first port
    input wire logic [7:0] PERIPH_DATA,
    input wire logic PERIPH_OE,
    // Interrupt inputs
    input wire logic [7:0] IRQ_IN,
    // Configuration outputs
    output logic [3:0] PAGE,
    output logic SRAM_PROG_SPACE,
    output logic PERIPH_MODE_A,
    output logic [7:0] POWER_CFG_A,
    output logic [7:0] POWER_CFG_B,
    output logic [7:0] IRQ_TOP,
    output logic IN_RESET
);
    import cfg_bank_pkg::*;

    function automatic io_sel_t io_decode(input logic [7:0] a);
        io_sel_t s;
        s.port = {a[5:4], a[0]};
        s.field = a[3:1];
        s.hit = (a[7:6] == 2'h0) && (s.port < 3'h5) && (s.field != 3'h7);
        return s;
    endfunction
    function automatic logic [7:0] lowest_one(input logic [7:0] x);
        return x & (~x + 8'h01);
    endfunction
    rst_state_t st;
    logic [15:0] hold_cnt;
    logic in_reset;
    logic [4:0][7:0] mode_ctl, data_out, direction, drive_type, special_fn, macro_q;
    logic [7:0] mem_mode, irq_sense, irq_enable, irq_prev, edge_latch;
    logic [7:0] tmr_global, tmr_delay, tmr_freeze;
    logic [3:0][7:0] tmr_cfg;
    logic [3:0] freeze_ack;
    logic [3:0][15:0] tmr_count, tmr_snap;
    logic [7:0] pending, next_rdata;
    logic wr_ok, rd_ok, clr_rd;
    io_sel_t io;
    pin_drive_t [4:0] next_drive;
    logic drain_sel, logic_sel;
    assign in_reset = (st != ST_RUN);
    assign wr_ok = REG_REQ.sel && REG_REQ.wr && !in_reset;
    assign rd_ok = REG_REQ.sel && REG_REQ.rd;
    assign io = io_decode(REG_REQ.addr);
    assign clr_rd = rd_ok && (REG_REQ.addr == `CFG_OFS_IRQ_CLEAR);
    assign drain_sel = 1'(`CFG_ODRAIN_PORTS >> io.port);
    assign logic_sel = 1'(`CFG_LOGIC_PORTS >> io.port);
    // Reset sequencer: holds the block after release
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st <= ST_HOLD;
            hold_cnt <= 16'h0000;
        end else begin
            case (st)
                ST_HOLD: begin
                    st <= ST_EXTEND;
                    hold_cnt <= 16'h0000;
                end
                ST_EXTEND: begin
                    hold_cnt <= hold_cnt + 16'h0001;
                    if (hold_cnt >= 16'(RESET_HOLD - 1)) begin
                        st <= ST_RUN;
                    end
                end
                ST_RUN: st <= ST_RUN;
                default: st <= ST_HOLD;
            endcase
        end
    end
    always_ff @(posedge CORE_CLK) begin
        IN_RESET <= SYS_RST || in_reset;
    end
    // Port configuration registers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mode_ctl <= '0;
            data_out <= '0;
            direction <= '0;
            drive_type <= '0;
            special_fn <= '0;
        end else if (wr_ok && io.hit) begin
            case (io.field)
                `CFG_FLD_MODE: mode_ctl[io.port] <= REG_REQ.wdata;
                `CFG_FLD_OUT: data_out[io.port] <= REG_REQ.wdata;
                `CFG_FLD_DIR: direction[io.port] <= REG_REQ.wdata;
                `CFG_FLD_DRV_SF: begin
                    if (drain_sel) begin
                        drive_type[io.port] <= REG_REQ.wdata;
                    end else begin
                        special_fn[io.port] <= REG_REQ.wdata;
                    end
                end
                default: ;
            endcase
        end
    end
    // Macrocell flip-flops: cleared only by their own reset sources
    always_ff @(posedge CORE_CLK) begin
        for (int p = 0; p < 5; p++) begin
            macro_q[p] <= MACRO_D[p] & ~MACRO_CLR_TERM[p] & {8{~MACROCELL_RESET_INPUT}};
        end
    end
    // Page, memory mode and power registers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            PAGE <= `CFG_RESET_PAGE;
            mem_mode <= `CFG_RESET_BYTE;
            POWER_CFG_A <= `CFG_RESET_BYTE;
            POWER_CFG_B <= `CFG_RESET_BYTE;
        end else if (wr_ok) begin
            case (REG_REQ.addr)
                `CFG_OFS_PAGE: PAGE <= REG_REQ.wdata[3:0];
                `CFG_OFS_MEM_MODE: mem_mode <= REG_REQ.wdata;
                `CFG_OFS_PWR_A: POWER_CFG_A <= REG_REQ.wdata;
                `CFG_OFS_PWR_B: POWER_CFG_B <= REG_REQ.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            SRAM_PROG_SPACE <= 1'b0;
            PERIPH_MODE_A <= 1'b0;
        end else begin
            SRAM_PROG_SPACE <= mem_mode[`CFG_MEM_SRAM_PROG_BIT];
            PERIPH_MODE_A <= mem_mode[`CFG_MEM_PERIPH_A_BIT];
        end
    end
    // Interrupt controller
    assign pending = ((irq_sense & edge_latch) | (~irq_sense & IRQ_IN)) & irq_enable;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            irq_sense <= `CFG_RESET_BYTE;
            irq_enable <= `CFG_RESET_BYTE;
        end else if (wr_ok) begin
            if (REG_REQ.addr == `CFG_OFS_IRQ_SENSE) begin
                irq_sense <= REG_REQ.wdata;
            end
            if (REG_REQ.addr == `CFG_OFS_IRQ_ENABLE) begin
                irq_enable <= REG_REQ.wdata;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            irq_prev <= `CFG_RESET_BYTE;
            edge_latch <= `CFG_RESET_BYTE;
            IRQ_TOP <= `CFG_RESET_BYTE;
        end else begin
            irq_prev <= IRQ_IN;
            // New edge wins over a simultaneous read-clear
            edge_latch <= (edge_latch & ~{8{clr_rd}}) | (IRQ_IN & ~irq_prev & irq_sense & irq_enable);
            IRQ_TOP <= lowest_one(pending);
        end
    end
    // Timer control registers and freeze handshake
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            tmr_global <= `CFG_RESET_BYTE;
            tmr_delay <= `CFG_RESET_BYTE;
            tmr_freeze <= `CFG_RESET_BYTE;
            tmr_cfg <= '0;
            freeze_ack <= 4'h0;
        end else begin
            freeze_ack <= tmr_freeze[3:0];
            if (wr_ok) begin
                case (REG_REQ.addr)
                    `CFG_OFS_TMR_GLOBAL: tmr_global <= REG_REQ.wdata;
                    `CFG_OFS_TMR_DELAY: tmr_delay <= REG_REQ.wdata;
                    `CFG_OFS_TMR_FREEZE: tmr_freeze <= REG_REQ.wdata;
                    default: begin
                        if (REG_REQ.addr[7:2] == `CFG_TMR_CFG_TAG) begin
                            tmr_cfg[REG_REQ.addr[1:0]] <= REG_REQ.wdata;
                        end
                    end
                endcase
            end
        end
    end
    // Counters and images; contents undefined after reset
    always_ff @(posedge CORE_CLK) begin
        for (int n = 0; n < 4; n++) begin
            if (wr_ok && REG_REQ.addr[7:3] == `CFG_TMR_COUNT_TAG && REG_REQ.addr[2:1] == 2'(n)) begin
                tmr_count[n][8*REG_REQ.addr[0] +: 8] <= REG_REQ.wdata;
            end else if (wr_ok && REG_REQ.addr == `CFG_OFS_TMR_LDST && REG_REQ.wdata[4+n]) begin
                tmr_count[n] <= tmr_snap[n];
            end else if (tmr_global[`CFG_TMR_RUN_BIT] && !freeze_ack[n] && !in_reset) begin
                tmr_count[n] <= tmr_count[n] - 16'h0001;
            end
            // Image writes only land once the freeze is acknowledged
            if (wr_ok && freeze_ack[n] && REG_REQ.addr[7:3] == `CFG_TMR_SNAP_TAG
                    && REG_REQ.addr[2:1] == 2'(n)) begin
                tmr_snap[n][8*REG_REQ.addr[0] +: 8] <= REG_REQ.wdata;
            end else if (wr_ok && REG_REQ.addr == `CFG_OFS_TMR_LDST && REG_REQ.wdata[n]) begin
                tmr_snap[n] <= tmr_count[n];
            end
        end
    end
    // Read data selection
    always_comb begin
        next_rdata = `CFG_RESET_BYTE;
        if (io.hit) begin
            case (io.field)
                `CFG_FLD_PIN_IN: next_rdata = PIN_IN[io.port];
                `CFG_FLD_MODE: next_rdata = mode_ctl[io.port];
                `CFG_FLD_OUT: next_rdata = data_out[io.port];
                `CFG_FLD_DIR: next_rdata = direction[io.port];
                `CFG_FLD_DRV_SF: next_rdata = drain_sel ? drive_type[io.port] : special_fn[io.port];
                `CFG_FLD_LOGIC: next_rdata = logic_sel ? LOGIC_PIN_CFG[io.port] : `CFG_RESET_BYTE;
                `CFG_FLD_MACRO: next_rdata = logic_sel ? macro_q[io.port] : `CFG_RESET_BYTE;
                default: next_rdata = `CFG_RESET_BYTE;
            endcase
        end else begin
            case (REG_REQ.addr)
                `CFG_OFS_PAGE: next_rdata = {4'h0, PAGE};
                `CFG_OFS_IRQ_CLEAR: next_rdata = pending;
                `CFG_OFS_IRQ_ENABLE: next_rdata = irq_enable;
                `CFG_OFS_IRQ_SENSE: next_rdata = irq_sense;
                `CFG_OFS_IRQ_PENDING: next_rdata = pending;
                `CFG_OFS_IRQ_TOP: next_rdata = lowest_one(pending);
                `CFG_OFS_MEM_MODE: next_rdata = mem_mode;
                `CFG_OFS_PWR_A: next_rdata = POWER_CFG_A;
                `CFG_OFS_PWR_B: next_rdata = POWER_CFG_B;
                `CFG_OFS_TMR_FLAGS: next_rdata = {4'h0, freeze_ack};
                `CFG_OFS_TMR_GLOBAL: next_rdata = tmr_global;
                `CFG_OFS_TMR_DELAY: next_rdata = tmr_delay;
                `CFG_OFS_TMR_FREEZE: next_rdata = tmr_freeze;
                default: begin
                    if (REG_REQ.addr[7:2] == `CFG_TMR_CFG_TAG) begin
                        next_rdata = tmr_cfg[REG_REQ.addr[1:0]];
                    end else if (REG_REQ.addr[7:3] == `CFG_TMR_COUNT_TAG) begin
                        next_rdata = tmr_count[REG_REQ.addr[2:1]][8*REG_REQ.addr[0] +: 8];
                    end else if (REG_REQ.addr[7:3] == `CFG_TMR_SNAP_TAG) begin
                        next_rdata = tmr_snap[REG_REQ.addr[2:1]][8*REG_REQ.addr[0] +: 8];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= `CFG_RESET_BYTE;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= rd_ok;
            if (rd_ok) begin
                REG_RDATA <= next_rdata;
            end
        end
    end
    // Pin drive selection
    always_comb begin
        next_drive = '0;
        for (int p = 0; p < 5; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (LOGIC_PIN_CFG[p][b]) begin
                    next_drive[p].out[b] = LOGIC_OUT[p][b];
                    next_drive[p].oe[b] = LOGIC_OE[p][b];
                end else if (in_reset) begin
                    next_drive[p].out[b] = 1'b0;
                    next_drive[p].oe[b] = 1'b0;
                end else if (p == `CFG_PERIPH_PORT && mem_mode[`CFG_MEM_PERIPH_A_BIT]) begin
                    next_drive[p].out[b] = PERIPH_DATA[b];
                    next_drive[p].oe[b] = PERIPH_OE;
                end else if (special_fn[p][b]) begin
                    next_drive[p].out[b] = SPECIAL_SRC[p][b];
                    next_drive[p].oe[b] = 1'b1;
                end else if (!mode_ctl[p][b]) begin
                    next_drive[p].out[b] = ADDR_SRC[p][b];
                    next_drive[p].oe[b] = 1'b1;
                end else begin
                    next_drive[p].out[b] = data_out[p][b];
                    next_drive[p].oe[b] = direction[p][b];
                end
                if (drive_type[p][b] && !LOGIC_PIN_CFG[p][b]) begin
                    next_drive[p].oe[b] = next_drive[p].oe[b] & ~next_drive[p].out[b];
                    next_drive[p].out[b] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        PIN_DRIVE <= next_drive;
    end

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_pin_in_read: assert property (
        rd_ok && REG_REQ.addr == `CFG_OFS_PORT_A_IN |=> REG_RDATA == $past(PIN_IN[0]) && REG_RVALID)
        else $error("pin input read mismatch");
    a_mode_addr_out: assert property (
        !in_reset && !mode_ctl[3][0] && !LOGIC_PIN_CFG[3][0] && !drive_type[3][0]
        |=> PIN_DRIVE[3].out[0] == $past(ADDR_SRC[3][0]) && PIN_DRIVE[3].oe[0])
        else $error("address out mode not driving");
    a_mcu_io_drive: assert property (
        !in_reset |=> (((PIN_DRIVE[2].out ^ $past(data_out[2])) | (PIN_DRIVE[2].oe ^ $past(direction[2])))
        & $past(mode_ctl[2] & ~drive_type[2] & ~LOGIC_PIN_CFG[2] & ~special_fn[2])) == 8'h00)
        else $error("general io drive mismatch");
    a_open_drain_low: assert property (
        1'b1 |=> (PIN_DRIVE[2].out & $past(drive_type[2] & ~LOGIC_PIN_CFG[2])) == 8'h00)
        else $error("open drain pin driven high");
    a_special_route: assert property (
        !in_reset && special_fn[1][0] && !LOGIC_PIN_CFG[1][0] && !drive_type[1][0]
        |=> PIN_DRIVE[1].out[0] == $past(SPECIAL_SRC[1][0]) && PIN_DRIVE[1].oe[0])
        else $error("special function not routed");
    a_page_write: assert property (
        wr_ok && REG_REQ.addr == `CFG_OFS_PAGE |=> PAGE == $past(REG_REQ.wdata[3:0]))
        else $error("page register not updated");
    a_edge_clear: assert property (
        clr_rd && (IRQ_IN & ~irq_prev) == 8'h00 |=> edge_latch == 8'h00)
        else $error("read clear left edge pending");
    a_level_pending: assert property (
        rd_ok && REG_REQ.addr == `CFG_OFS_IRQ_PENDING
        |=> ((REG_RDATA ^ $past(IRQ_IN)) & $past(~irq_sense & irq_enable)) == 8'h00)
        else $error("level pending mismatch");
    a_priority_top: assert property (
        1'b1 |=> IRQ_TOP == lowest_one($past(pending)) && $onehot0(IRQ_TOP))
        else $error("priority status wrong");
    a_freeze_ack: assert property (
        wr_ok && REG_REQ.addr == `CFG_OFS_TMR_FREEZE ##1 !(wr_ok && REG_REQ.addr == `CFG_OFS_TMR_FREEZE)
        |=> freeze_ack == $past(REG_REQ.wdata[3:0], 2))
        else $error("freeze not acknowledged");
    a_reset_hold: assert property (
        $fell(SYS_RST) |-> in_reset ##1 (st == ST_EXTEND && in_reset))
        else $error("reset not extended");
    a_reset_zero: assert property (
        $fell(SYS_RST) |-> PAGE == 4'h0 && irq_enable == 8'h00 && mode_ctl == '0 && freeze_ack == 4'h0)
        else $error("register not zero after reset");
    a_macro_clear: assert property (
        MACROCELL_RESET_INPUT |=> macro_q == '0)
        else $error("macrocell not cleared");

    c_edge_then_clear: cover property (irq_sense[0] && edge_latch[0] ##[1:8] clr_rd);
    c_freeze_image: cover property (freeze_ack[0] && wr_ok && REG_REQ.addr[7:3] == `CFG_TMR_SNAP_TAG);
    c_open_drain_use: cover property (!in_reset && drive_type[2] != 8'h00 && mode_ctl[2] != 8'h00);
    c_reset_release: cover property (in_reset ##1 !in_reset);
endmodule
`default_nettype wire

// ---- bench/host_bus_model.sv ----
// Host microcontroller model issuing register bus cycles
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock
    input wire logic clk,
    // Register bus
    output cfg_bank_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import cfg_bank_pkg::*;
    initial req = '0;
    // Released lines show inverted data, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{sel: 1'b1, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        req <= '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        req <= '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        @(negedge clk);
        v = rvalid;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ---- bench/config_register_bank_tb_top.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_map.svh"
module config_register_bank_tb_top;
    import cfg_bank_pkg::*;
    logic clk, rst, mrst, poe, rvalid, in_rst, sram, pmode;
    reg_req_t req;
    logic [7:0] rdata, pdata, irq_in, top, pwa, pwb;
    logic [4:0][7:0] pin_in, asrc, ssrc, lcfg, lout, loe, md, mclr;
    pin_drive_t [4:0] drv;
    logic [3:0] page;
    int n_mismatch = 0;
    int cmp_count = 0;
    config_register_bank #(.RESET_HOLD(2)) dut (.CORE_CLK(clk), .SYS_RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .PIN_IN(pin_in), .ADDR_SRC(asrc), .SPECIAL_SRC(ssrc), .PIN_DRIVE(drv),
        .LOGIC_PIN_CFG(lcfg), .LOGIC_OUT(lout), .LOGIC_OE(loe), .MACRO_D(md), .MACRO_CLR_TERM(mclr),
        .MACROCELL_RESET_INPUT(mrst), .PERIPH_DATA(pdata), .PERIPH_OE(poe), .IRQ_IN(irq_in), .PAGE(page),
        .SRAM_PROG_SPACE(sram), .PERIPH_MODE_A(pmode), .POWER_CFG_A(pwa), .POWER_CFG_B(pwb), .IRQ_TOP(top),
        .IN_RESET(in_rst));
    host_bus_model host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    task automatic complete_run();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        chk("rvalid", 8'h01, {7'h00, v});
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic wait_ready();
        @(negedge clk);
        chk("in_reset hold", 8'h01, {7'h00, in_rst});
        for (int i = 0; i < 50 && in_rst !== 1'b0; i++) @(posedge clk);
        chk("in_reset", 8'h00, {7'h00, in_rst});
    endtask
    task automatic t_reset_vals();
        logic [7:0] ofs [10] = '{8'h02, 8'h04, 8'h06, 8'h18, 8'he0, 8'hc0, 8'hb0, 8'hd3, 8'ha8, 8'ha9};
        foreach (ofs[i]) rdc(ofs[i], 8'h00);
    endtask
    task automatic t_page();
        host.wr(`CFG_OFS_PAGE, 8'h0a);
        rdc(`CFG_OFS_PAGE, 8'h0a);
        chk("page", 8'h0a, {4'h0, page});
        host.wr(8'hf0, 8'h55);
        rdc(8'hf0, 8'h00);
        host.wr(`CFG_OFS_PWR_A, 8'ha5);
        host.wr(`CFG_OFS_PWR_B, 8'h3c);
        rdc(`CFG_OFS_PWR_B, 8'h3c);
        chk("power a", 8'ha5, pwa);
        chk("power b", 8'h3c, pwb);
    endtask
    task automatic t_port_b();
        @(posedge clk);
        pin_in[1] <= 8'ha5;
        pin_in[0] <= 8'h3c;
        asrc[1] <= 8'h5a;
        rdc(8'h01, 8'ha5);
        rdc(8'h00, 8'h3c);
        host.wr(8'h03, 8'h0f);
        host.wr(8'h07, 8'hff);
        host.wr(8'h05, 8'h3c);
        repeat (3) @(negedge clk);
        chk("b out", 8'h5c, drv[1].out);
        chk("b oe", 8'hff, drv[1].oe);
        host.wr(8'h07, 8'h03);
        repeat (3) @(negedge clk);
        chk("b oe dir", 8'h03, drv[1].oe & 8'h0f);
        @(posedge clk);
        ssrc[1] <= 8'h01;
        host.wr(8'h09, 8'h01);
        repeat (3) @(negedge clk);
        chk("b special", 8'h03, {6'h00, drv[1].out[0], drv[1].oe[0]});
    endtask
    task automatic t_drain();
        host.wr(8'h12, 8'hff);
        host.wr(8'h16, 8'hff);
        host.wr(8'h14, 8'hf0);
        host.wr(8'h18, 8'h0f);
        repeat (3) @(negedge clk);
        chk("c out", 8'hf0, drv[2].out);
        chk("c oe", 8'hff, drv[2].oe);
        host.wr(8'h14, 8'hff);
        repeat (3) @(negedge clk);
        chk("c oe high", 8'hf0, drv[2].oe);
    endtask
    task automatic t_logic();
        @(posedge clk);
        lcfg[4] <= 8'h81;
        lout[4] <= 8'hff;
        loe[4] <= 8'h01;
        rdc(8'h2a, 8'h81);
        host.wr(8'h2a, 8'h00);
        rdc(8'h2a, 8'h81);
        @(posedge clk);
        md[4] <= 8'h3c;
        rdc(8'h2c, 8'h3c);
        @(posedge clk);
        mclr[4] <= 8'h0c;
        rdc(8'h2c, 8'h30);
        @(posedge clk);
        mrst <= 1'b1;
        rdc(8'h2c, 8'h00);
        @(posedge clk);
        mrst <= 1'b0;
    endtask
    task automatic t_irq();
        host.wr(`CFG_OFS_IRQ_SENSE, 8'h01);
        host.wr(`CFG_OFS_IRQ_ENABLE, 8'h03);
        @(posedge clk);
        irq_in <= 8'h07;
        @(posedge clk);
        irq_in <= 8'h06;
        rdc(`CFG_OFS_IRQ_PENDING, 8'h03);
        chk("irq top", 8'h01, top);
        rdc(`CFG_OFS_IRQ_CLEAR, 8'h03);
        rdc(`CFG_OFS_IRQ_PENDING, 8'h02);
        rdc(`CFG_OFS_IRQ_TOP, 8'h02);
    endtask
    task automatic t_timer_mem();
        host.wr(`CFG_OFS_TMR_FREEZE, 8'h01);
        rdc(`CFG_OFS_TMR_FLAGS, 8'h01);
        host.wr(8'h90, 8'h5a);
        rdc(8'h90, 8'h5a);
        host.wr(8'h91, 8'h12);
        host.wr(`CFG_OFS_TMR_LDST, 8'h10);
        rdc(8'h99, 8'h12);
        rdc(8'h98, 8'h5a);
        @(posedge clk);
        pdata <= 8'hc3;
        poe <= 1'b1;
        host.wr(`CFG_OFS_MEM_MODE, 8'h03);
        repeat (3) @(negedge clk);
        chk("sram prog", 8'h01, {7'h00, sram});
        chk("periph a", 8'h01, {7'h00, pmode});
        chk("a out", 8'hc3, drv[0].out);
    endtask
    task automatic t_rerun();
        @(posedge clk);
        rst <= 1'b1;
        host.wr(`CFG_OFS_PAGE, 8'h03);
        repeat (2) @(negedge clk);
        chk("b oe rst", 8'h00, drv[1].oe);
        chk("e logic oe", 8'h01, drv[4].oe & 8'h81);
        @(posedge clk);
        rst <= 1'b0;
        wait_ready();
        rdc(`CFG_OFS_PAGE, 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200us;
        n_mismatch++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        mrst = 1'b0;
        poe = 1'b0;
        pdata = 8'h00;
        irq_in = 8'h00;
        {pin_in, asrc, ssrc, lcfg, lout, loe, md, mclr} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wait_ready();
        t_reset_vals();
        t_page();
        t_port_b();
        t_drain();
        t_logic();
        t_irq();
        t_timer_mem();
        t_rerun();
        complete_run();
    end
endmodule
`default_nettype wire
